// ===== include/i2c_regs_pkg.sv
// register map, field layout and bus event carriers of the serial bus status block
package i2c_regs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_OWN_ADDR  = 8'h00;
    localparam logic [7:0] OFS_INT_EN    = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_SCL_LO    = 8'h0c;
    localparam logic [7:0] OFS_SCL_HI    = 8'h10;
    localparam logic [7:0] OFS_COUNT     = 8'h14;
    localparam logic [7:0] OFS_RX_DATA   = 8'h18;
    localparam logic [7:0] OFS_TARGET    = 8'h1c;
    localparam logic [7:0] OFS_TX_DATA   = 8'h20;
    localparam logic [7:0] OFS_MODE      = 8'h24;
    localparam logic [7:0] OFS_VECTOR    = 8'h28;
    localparam logic [7:0] OFS_EXT_MODE  = 8'h2c;
    localparam logic [7:0] OFS_PRESCALE  = 8'h30;
    localparam logic [7:0] OFS_IDENT_1   = 8'h34;
    localparam logic [7:0] OFS_IDENT_2   = 8'h38;
    // identification words, values arbitrary
    localparam logic [31:0] IDENT_1_VAL  = 32'h0000_0101;
    localparam logic [31:0] IDENT_2_VAL  = 32'h0000_0002;
    // status bit positions
    localparam int ST_AL    = 0;
    localparam int ST_NACK  = 1;
    localparam int ST_REGISTER_ACCESS_READY_FLAG  = 2;
    localparam int ST_RRDY  = 3;
    localparam int ST_XRDY  = 4;
    localparam int ST_SCD   = 5;
    localparam int ST_AD0   = 8;
    localparam int ST_AAS   = 9;
    localparam int ST_TRANSMIT_SHIFT_EMPTY_FLAG  = 10;
    localparam int ST_OVR   = 11;
    localparam int ST_BB    = 12;
    localparam int ST_NSNT  = 13;
    localparam int ST_SLAVE_DIRECTION_FLAG  = 14;
    localparam logic [14:0] STATUS_RST   = 15'h0410;
    localparam logic [14:0] STATUS_W1C   = 15'h703f;
    // mode register fields
    localparam int MD_DLB   = 3;
    localparam int MD_IRS   = 5;
    localparam int MD_XA    = 8;
    localparam int MD_STT   = 13;
    localparam logic [15:0] MODE_WMASK   = 16'h0128;
    localparam logic [15:0] MODE_RST     = 16'h0000;
    localparam logic [6:0]  INT_EN_RST   = 7'h00;
    // events from the shifter and acknowledge logic, same clock
    typedef struct packed {
        logic       al;
        logic       nack;
        logic       register_access_ready_flag;
        logic       rx_full;
        logic [7:0] rx_byte;
        logic       tx_copied;
        logic       tx_underflow;
        logic       slave_tx;
        logic       nack_driven;
        logic       addr_seen;
        logic       gen_call;
        logic       start_sent;
        logic       stop_sent;
    } bus_ev_t;
    // settings handed to the rest of the controller
    typedef struct packed {
        logic        enable;
        logic        ext_addr;
        logic        loopback;
        logic [15:0] scl_lo;
        logic [15:0] scl_hi;
        logic [15:0] count;
        logic [9:0]  target;
        logic [7:0]  tx_byte;
        logic [7:0]  prescale;
        logic [1:0]  ext_mode;
    } cfg_t;
endpackage

// ===== core/sync2.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage only feeds the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            q        <= '1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ===== core/i2c_status_regs.sv
// register file, status flags and interrupt of the two-wire bus controller
`timescale 1ns/1ps
module i2c_status_regs
    import i2c_regs_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // shifter side
    input  wire bus_ev_t     ev,
    input  wire logic [9:0]  bus_addr,
    output logic             addr_match,
    output logic             start_req,
    output logic             restart_req,
    output logic             rx_hold,
    output cfg_t             cfg,
    // interrupt
    output logic             irq
);
    logic [9:0]  own_addr_reg;
    logic [6:0]  int_en_reg;
    logic [14:0] st_reg;
    logic [14:0] st_next;
    logic [15:0] mode_reg;
    logic [7:0]  rx_data_reg;
    logic [31:0] rdata_next;
    logic        err_next;
    logic [2:0]  vec_code;
    logic [2:0]  vec_code_reg;
    logic [1:0]  pins_s;
    logic        scl_q;
    logic        sda_q;
    logic        start_det;
    logic        stop_det;
    logic        start_evt;
    logic        stop_evt;
    logic        any_pend_q;
    logic        vec_read_q;
    logic        setup;
    logic        wr;
    logic        rd;
    logic [6:0]  pend;
    logic [14:0] set_m;
    logic [14:0] clr_m;

    // bus lines cross into pclk before anything looks at them
    sync2 #(.W(2)) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({scl_in, sda_in}),
        .q       (pins_s)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= pins_s[1];
            sda_q <= pins_s[0];
        end
    end

    // data edge while clock stays high marks START or STOP
    assign start_det = pins_s[1] & scl_q & sda_q & ~pins_s[0];
    assign stop_det  = pins_s[1] & scl_q & ~sda_q & pins_s[0];
    assign start_evt = start_det | ev.start_sent;
    assign stop_evt  = stop_det | ev.stop_sent;

    // apb phases; every access finishes in its first access cycle
    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite;
    assign rd     = psel & penable & ~pwrite;
    assign pready = 1'b1;

    // plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_addr_reg <= '0;
            int_en_reg   <= INT_EN_RST;
            mode_reg     <= MODE_RST;
            cfg          <= '0;
        end else begin
            if (wr) begin
                case (paddr)
                    OFS_OWN_ADDR: own_addr_reg <= pwdata[9:0];
                    OFS_INT_EN:   int_en_reg   <= pwdata[6:0];
                    OFS_MODE:     mode_reg     <= pwdata[15:0] & MODE_WMASK;
                    OFS_SCL_LO:   cfg.scl_lo   <= pwdata[15:0];
                    OFS_SCL_HI:   cfg.scl_hi   <= pwdata[15:0];
                    OFS_COUNT:    cfg.count    <= pwdata[15:0];
                    OFS_TARGET:   cfg.target   <= pwdata[9:0];
                    OFS_TX_DATA:  cfg.tx_byte  <= pwdata[7:0];
                    OFS_PRESCALE: cfg.prescale <= pwdata[7:0];
                    OFS_EXT_MODE: cfg.ext_mode <= pwdata[1:0];
                    default: ;
                endcase
            end
            cfg.enable   <= mode_reg[MD_IRS];
            cfg.ext_addr <= mode_reg[MD_XA];
            cfg.loopback <= mode_reg[MD_DLB];
        end
    end

    // start command is a strobe; a busy bus turns it into a restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_req   <= 1'b0;
            restart_req <= 1'b0;
        end else begin
            start_req   <= wr && paddr == OFS_MODE && pwdata[MD_STT] && !st_reg[ST_BB];
            restart_req <= wr && paddr == OFS_MODE && pwdata[MD_STT] && st_reg[ST_BB];
        end
    end

    // own address compare, registered for the shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_match <= 1'b0;
        end else if (mode_reg[MD_XA]) begin
            addr_match <= bus_addr == own_addr_reg;
        end else begin
            addr_match <= bus_addr[6:0] == own_addr_reg[6:0];
        end
    end

    // enabled pending flags in vector priority order
    assign pend = int_en_reg & {st_reg[ST_AAS], st_reg[ST_SCD:ST_AL]};

    always_comb begin
        vec_code = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (pend[i]) begin
                vec_code = 3'(i + 1);
            end
        end
    end

    // status set and clear masks; a set in the same cycle beats a clear
    always_comb begin
        set_m = '0;
        clr_m = '0;
        set_m[ST_AL]   = ev.al;
        set_m[ST_NACK] = ev.nack;
        set_m[ST_REGISTER_ACCESS_READY_FLAG] = ev.register_access_ready_flag;
        set_m[ST_RRDY] = ev.rx_full & (~st_reg[ST_RRDY] | (rd && paddr == OFS_RX_DATA));
        set_m[ST_XRDY] = ev.tx_copied;
        set_m[ST_SCD]  = stop_evt;
        set_m[ST_AD0]  = ev.gen_call;
        set_m[ST_AAS]  = ev.addr_seen | ev.gen_call;
        set_m[ST_TRANSMIT_SHIFT_EMPTY_FLAG] = wr && paddr == OFS_TX_DATA;
        set_m[ST_OVR]  = ev.rx_full & st_reg[ST_RRDY]
                       & ~(rd && paddr == OFS_RX_DATA);
        set_m[ST_BB]   = start_evt | (~pins_s[1] & ~mode_reg[MD_IRS]);
        set_m[ST_NSNT] = ev.nack_driven;
        set_m[ST_SLAVE_DIRECTION_FLAG] = ev.slave_tx;
        if (wr && paddr == OFS_STATUS) begin
            clr_m = pwdata[14:0] & STATUS_W1C;
        end
        if (rd && paddr == OFS_VECTOR && vec_code_reg != 3'h0) begin
            if (vec_code_reg == 3'h7) begin
                clr_m[ST_AAS] = 1'b1;
            end else begin
                clr_m[vec_code_reg - 3'h1] = 1'b1;
            end
        end
        if (rd && paddr == OFS_RX_DATA) begin
            clr_m[ST_RRDY] = 1'b1;
            clr_m[ST_OVR]  = 1'b1;
        end
        clr_m[ST_XRDY] = clr_m[ST_XRDY] | (wr && paddr == OFS_TX_DATA);
        clr_m[ST_TRANSMIT_SHIFT_EMPTY_FLAG] = ev.tx_underflow;
        clr_m[ST_BB]   = clr_m[ST_BB] | stop_evt;
        clr_m[ST_SLAVE_DIRECTION_FLAG] = clr_m[ST_SLAVE_DIRECTION_FLAG] | start_evt | stop_evt;
        clr_m[ST_AD0]  = start_evt | stop_evt;
        clr_m[ST_AAS]  = clr_m[ST_AAS] | start_evt | stop_evt;
        st_next = (st_reg & ~clr_m) | set_m;
        st_next[7:6] = 2'b00;
        if (mode_reg[MD_DLB]) begin
            st_next[ST_SLAVE_DIRECTION_FLAG] = 1'b0;
        end
        if (!mode_reg[MD_IRS]) begin
            // module reset holds reset values; busy still follows a low clock line
            st_next = STATUS_RST;
            st_next[ST_BB] = ~pins_s[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= STATUS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // receive data is not overwritten while unread; the shifter is held instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_reg <= '0;
        end else if (set_m[ST_RRDY] && mode_reg[MD_IRS]) begin
            rx_data_reg <= ev.rx_byte;
        end
    end
    assign rx_hold = st_reg[ST_OVR];

    // read data is built in the setup phase so prdata comes from a flop
    always_comb begin
        rdata_next = '0;
        err_next   = 1'b0;
        case (paddr)
            OFS_OWN_ADDR: rdata_next[9:0]  = own_addr_reg;
            OFS_INT_EN:   rdata_next[6:0]  = int_en_reg;
            OFS_STATUS:   rdata_next[14:0] = st_reg;
            OFS_SCL_LO:   rdata_next[15:0] = cfg.scl_lo;
            OFS_SCL_HI:   rdata_next[15:0] = cfg.scl_hi;
            OFS_COUNT:    rdata_next[15:0] = cfg.count;
            OFS_RX_DATA:  rdata_next[7:0]  = rx_data_reg;
            OFS_TARGET:   rdata_next[9:0]  = cfg.target;
            OFS_TX_DATA:  rdata_next[7:0]  = cfg.tx_byte;
            OFS_MODE:     rdata_next[15:0] = mode_reg;
            OFS_VECTOR:   rdata_next[2:0]  = vec_code;
            OFS_EXT_MODE: rdata_next[1:0]  = cfg.ext_mode;
            OFS_PRESCALE: rdata_next[7:0]  = cfg.prescale;
            OFS_IDENT_1:  rdata_next       = IDENT_1_VAL;
            OFS_IDENT_2:  rdata_next       = IDENT_2_VAL;
            default:      err_next         = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata       <= '0;
            pslverr      <= 1'b0;
            vec_code_reg <= 3'h0;
        end else if (setup) begin
            prdata       <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr      <= err_next;
            vec_code_reg <= vec_code; // code that the read will clear
        end
    end

    // one-clock pulse when enabled pending flags go from none to some, or after a vector read leaves more
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_pend_q <= 1'b0;
            vec_read_q <= 1'b0;
            irq        <= 1'b0;
        end else begin
            any_pend_q <= |pend;
            vec_read_q <= rd && paddr == OFS_VECTOR;
            irq        <= (|pend) & (~any_pend_q | vec_read_q) & ~irq;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_status_w1c(int b);
        wr && paddr == OFS_STATUS && pwdata[b];
    endsequence
    sequence s_bus_start;
        start_evt;
    endsequence

    property p_bb_start;
        s_bus_start ##0 mode_reg[MD_IRS] |=> st_reg[ST_BB];
    endproperty
    a_bb_start: assert property (p_bb_start) else $error("busy not set by START");

    property p_bb_stop;
        stop_evt && !start_evt && mode_reg[MD_IRS] |=> !st_reg[ST_BB];
    endproperty
    a_bb_stop: assert property (p_bb_stop) else $error("busy not cleared by STOP");

    property p_nsnt_w1c;
        s_status_w1c(ST_NSNT) ##0 !ev.nack_driven |=> !st_reg[ST_NSNT];
    endproperty
    a_nsnt_w1c: assert property (p_nsnt_w1c) else $error("nack sent not cleared");

    property p_slave_direction_flag_dlb;
        mode_reg[MD_DLB] |=> !st_reg[ST_SLAVE_DIRECTION_FLAG];
    endproperty
    a_slave_direction_flag_dlb: assert property (p_slave_direction_flag_dlb) else $error("direction set in loopback");

    property p_ovr_set;
        ev.rx_full && st_reg[ST_RRDY] && !rd && mode_reg[MD_IRS]
            |=> st_reg[ST_OVR] && rx_hold && $stable(rx_data_reg);
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

    property p_ovr_clr;
        rd && paddr == OFS_RX_DATA |=> !st_reg[ST_OVR];
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared by read");

    property p_irq_pulse;
        irq |=> !irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt wider than one clock");

    property p_restart;
        wr && paddr == OFS_MODE && pwdata[MD_STT] && st_reg[ST_BB]
            |=> restart_req && !start_req;
    endproperty
    a_restart: assert property (p_restart) else $error("no repeated START when busy");

    property p_reserved;
        setup && !pwrite && paddr == OFS_STATUS |=> prdata[31:15] == '0 && prdata[7:6] == '0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits not zero");

    property p_match7;
        !mode_reg[MD_XA] && bus_addr[6:0] == own_addr_reg[6:0] |=> addr_match;
    endproperty
    a_match7: assert property (p_match7) else $error("7-bit address not matched");

    property p_irq_masked;
        pend == '0 |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked event raised interrupt");
endmodule

// ===== verification/bus_side_model.sv
// behavioural far side of the status block: shifter events, bus address and bus lines
`timescale 1ns/1ps
module bus_side_model
    import i2c_regs_pkg::*;
(
    // clock
    input  wire logic  pclk,
    // towards the status block
    output bus_ev_t    ev,
    output logic [9:0] bus_addr,
    output logic       scl_in,
    output logic       sda_in
);
    // both lines have pull-ups, so a released line reads high
    initial begin
        ev       = '0;
        bus_addr = 10'h000;
        scl_in   = 1'b1;
        sda_in   = 1'b1;
    end
    // one-cycle event pulse, taken by the block at the edge that ends it
    task automatic fire(input bus_ev_t e);
        @(posedge pclk);
        ev <= e;
        @(posedge pclk);
        ev <= '0;
    endtask
    // address seen on the bus, held as a level
    task automatic show_addr(input logic [9:0] a);
        @(posedge pclk);
        bus_addr <= a;
    endtask
    // a slow device stretching the clock line
    task automatic hold_scl(input logic lvl);
        @(posedge pclk);
        scl_in <= lvl;
    endtask
    // START, one bit of the 800 ns link clock, STOP; edges kept off the pclk grid
    task automatic frame();
        #37;
        sda_in = 1'b0;
        #400 scl_in = 1'b0;
        #400 scl_in = 1'b1;
        #400 sda_in = 1'b1;
    endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the status and mask register block
`timescale 1ns/1ps
module tb_top
    import i2c_regs_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, err_seen;
    logic [7:0]  paddr, b1, b2;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, scl_in, sda_in, addr_match, start_req, restart_req;
    logic        rx_hold, irq;
    logic [9:0]  bus_addr, oa;
    bus_ev_t     ev;
    cfg_t        cfg;
    logic [31:0] expq [$];
    int          n_mismatch, num_checks, n;
    logic [31:0] rst_val [15] = '{2: 32'h0000_0410, 13: IDENT_1_VAL, 14: IDENT_2_VAL,
                                  default: 32'h0};
    logic [7:0]  rw_ofs [9] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h30, 8'h2c};
    logic [31:0] rw_msk [9] = '{32'h3ff, 32'h7f, 32'hffff, 32'hffff, 32'hffff, 32'h3ff,
                                32'hff, 32'hff, 32'h3};

    i2c_status_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in), .ev(ev), .bus_addr(bus_addr),
        .addr_match(addr_match), .start_req(start_req), .restart_req(restart_req),
        .rx_hold(rx_hold), .cfg(cfg), .irq(irq));
    bus_side_model PM (.pclk(pclk), .ev(ev), .bus_addr(bus_addr), .scl_in(scl_in),
        .sda_in(sda_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // the expected word is noted first; the monitor compares it when the read lands
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    // event pulse by bit position in the carrier, with a receive byte alongside
    task automatic evp(input int pos, input logic [7:0] b);
        PM.fire(bus_ev_t'((20'h1 << pos) | (20'(b) << 8)));
    endtask
    // counts high cycles of irq, start_req or restart_req over five edges
    task automatic pulses(input int s, output int c);
        logic [2:0] v;
        c = 0;
        repeat (5) begin
            @(posedge pclk);
            v = {restart_req, start_req, irq};
            c += int'(v[s] === 1'b1);
        end
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask

    // read monitor: completed reads are matched against the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (expq.size() == 0) n_mismatch++;
            else chk(prdata, expq.pop_front());
        end
    end
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        #(8000 * 100);
        n_mismatch++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(95892));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            rd(8'(4 * i), rst_val[i]);
        end
        rd(8'h3c, 32'h0);
        chk(32'(err_seen), 32'h1);
        for (int i = 0; i < 9; i++) begin
            wr(rw_ofs[i], 32'hffff_ffff);
            rd(rw_ofs[i], rw_msk[i]);
        end
        tend("map");
        // module still held in reset: busy follows the clock line
        PM.hold_scl(1'b0);
        repeat (5) @(posedge pclk);
        rd(8'h08, 32'h0000_1410);
        PM.hold_scl(1'b1);
        repeat (5) @(posedge pclk);
        rd(8'h08, 32'h0000_0410);
        tend("busy_in_reset");
        wr(8'h24, 32'h20);
        evp(1, 8'h00);
        rd(8'h08, 32'h0000_1410);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h0000_1410);
        wr(8'h24, 32'h2020);
        pulses(2, n);
        chk(32'(n), 32'h1);
        wr(8'h08, 32'h1000);
        rd(8'h08, 32'h0000_0410);
        wr(8'h24, 32'h2020);
        pulses(1, n);
        chk(32'(n), 32'h1);
        evp(5, 8'h00);
        rd(8'h08, 32'h0000_4410);
        evp(4, 8'h00);
        rd(8'h08, 32'h0000_6410);
        wr(8'h08, 32'h2000);
        rd(8'h08, 32'h0000_4410);
        evp(1, 8'h00);
        rd(8'h08, 32'h0000_1410);
        evp(5, 8'h00);
        evp(0, 8'h00);
        rd(8'h08, 32'h0000_0430);
        wr(8'h08, 32'h20);
        wr(8'h24, 32'h28);
        evp(5, 8'h00);
        rd(8'h08, 32'h0000_0410);
        wr(8'h24, 32'h20);
        tend("flags");
        b1 = 8'($urandom);
        b2 = 8'($urandom);
        evp(16, b1);
        rd(8'h08, 32'h0000_0418);
        evp(16, b2);
        rd(8'h08, 32'h0000_0c18);
        chk(32'(rx_hold), 32'h1);
        rd(8'h18, {24'h0, b1});
        rd(8'h08, 32'h0000_0410);
        chk(32'(rx_hold), 32'h0);
        tend("overrun");
        wr(8'h04, 32'h08);
        evp(16, b2);
        pulses(0, n);
        chk(32'(n), 32'h1);
        rd(8'h28, 32'h4);
        rd(8'h18, {24'h0, b2});
        wr(8'h04, 32'h0);
        evp(16, b1);
        pulses(0, n);
        chk(32'(n), 32'h0);
        wr(8'h04, 32'h18);
        pulses(0, n);
        chk(32'(n), 32'h1);
        rd(8'h28, 32'h4);
        pulses(0, n);
        chk(32'(n), 32'h1);
        rd(8'h28, 32'h5);
        rd(8'h08, 32'h0000_0400);
        rd(8'h18, {24'h0, b1});
        tend("interrupt");
        // general call raises the slave flags; vector code 7 clears only addressed-as-slave
        wr(8'h04, 32'h40);
        evp(2, 8'h00);
        pulses(0, n);
        chk(32'(n), 32'h1);
        rd(8'h28, 32'h7);
        rd(8'h08, 32'h0000_0500);
        evp(1, 8'h00);
        rd(8'h08, 32'h0000_1400);
        wr(8'h08, 32'h1000);
        // underflow, refill and copy walk the transmit flags back to their idle pair
        evp(6, 8'h00);
        wr(8'h20, 32'h5a);
        evp(7, 8'h00);
        pulses(0, n);
        chk(32'(n), 32'h0);
        rd(8'h08, 32'h0000_0410);
        tend("events");
        oa = 10'($urandom);
        wr(8'h00, {22'h3f_ffff, oa});
        rd(8'h00, {22'h0, oa});
        PM.show_addr({~oa[9:7], oa[6:0]});
        repeat (3) @(posedge pclk);
        chk(32'(addr_match), 32'h1);
        wr(8'h24, 32'h120);
        repeat (3) @(posedge pclk);
        chk(32'(addr_match), 32'h0);
        PM.show_addr(oa);
        repeat (3) @(posedge pclk);
        chk(32'(addr_match), 32'h1);
        tend("address");
        // a real START and STOP on the pins, busy read in between
        fork
            PM.frame();
            begin
                repeat (7) @(posedge pclk);
                rd(8'h08, 32'h0000_1410);
            end
        join
        repeat (6) @(posedge pclk);
        rd(8'h08, 32'h0000_0430);
        evp(1, 8'h00);
        wr(8'h24, 32'h0);
        rd(8'h08, 32'h0000_0410);
        wr(8'h24, 32'h20);
        evp(4, 8'h00);
        evp(1, 8'h00);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h08, 32'h0000_0410);
        tend("pins_and_resets");
        repeat (4) @(posedge pclk);
        close_out();
    end
endmodule
